// [src/adc_offset_correction.sv]
/*
  Offset and no-load correction for a two-channel power monitor:
  AXI4-Lite register file for the 24-bit converter offsets and the AC/DC
  offset terms, mode control, save handshake and the offset adder.
  Assumes one clock, synchronous active-high reset, a master that holds
  valid and payload until taken, and a nonvolatile store that answers a
  save request with a done pulse.
*/
`timescale 1ns/100ps
`include "offset_corr_params.svh"
module adc_offset_correction (
  input wire logic mclk_i,
  input wire logic reset_i,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Converter codes
  input wire offset_corr_pkg::code_t current_code_i,
  input wire offset_corr_pkg::code_t voltage_code_i,
  input wire logic code_valid_i,
  output offset_corr_pkg::code_t corrected_current_o,
  output offset_corr_pkg::code_t corrected_voltage_o,
  output logic corrected_valid_o,
  // Calculation path controls
  output logic hpf_bypass_o,
  output offset_corr_pkg::half_t offset_irms_o,
  output offset_corr_pkg::half_t offset_active_o,
  output offset_corr_pkg::half_t offset_reactive_o,
  // Nonvolatile store handshake
  output logic save_request_o,
  input wire logic save_done_i
);
  import offset_corr_pkg::*;

  // Register file indices returned by the address decoder
  // Unmapped addresses fall to IDX_NONE and answer with an error,
  // so a stray access never lands in a live register
  localparam logic [3:0] IDX_UPPER = 4'h0;
  localparam logic [3:0] IDX_CUR = 4'h1;
  localparam logic [3:0] IDX_VOLT = 4'h2;
  localparam logic [3:0] IDX_CTRL = 4'h3;
  localparam logic [3:0] IDX_STATUS = 4'h4;
  localparam logic [3:0] IDX_AC_IRMS = 4'h5;
  localparam logic [3:0] IDX_AC_ACT = 4'h6;
  localparam logic [3:0] IDX_AC_REACT = 4'h7;
  localparam logic [3:0] IDX_DC_IRMS = 4'h8;
  localparam logic [3:0] IDX_DC_ACT = 4'h9;
  localparam logic [3:0] IDX_NONE = 4'hf;

  // All state of the block except the adder in one record
  // One record keeps reset and next-state handling in one place;
  // the cost is that every field is written on every clock
  typedef struct packed {
    half_t upper;        // Both channels' offset bits 23..16
    half_t cur_low;      // Current channel offset bits 15..0
    half_t volt_low;     // Voltage channel offset bits 15..0
    half_t ac_irms;      // AC current RMS offset term
    half_t ac_act;       // AC active power offset term
    half_t ac_react;     // AC reactive power offset term
    half_t dc_irms;      // DC current RMS offset term
    half_t dc_act;       // DC active power offset term
    logic dc_mode;       // Operating mode, 1 = DC
    save_state_e save;   // Save handshake state
    logic save_req;      // Save request pulse
    logic aw_full;       // Write address held
    logic [7:0] aw_addr;
    logic w_full;        // Write data held
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic hpf_bypass;
    half_t off_irms;     // Term selected for the current RMS path
    half_t off_act;      // Term selected for the active power path
    half_t off_react;    // Term selected for the reactive power path
  } top_s;

  top_s state;
  top_s next_state;
  offset_if offs ();

  // Address to register index; shared by the read and write paths
  // Only whole aligned words decode; the low address bits must be zero
  function automatic logic [3:0] reg_index(input logic [7:0] addr);
    logic [3:0] idx;
    idx = IDX_NONE;
    case (addr)
      `REG_UPPER_BYTES: idx = IDX_UPPER;
      `REG_CUR_LOW: idx = IDX_CUR;
      `REG_VOLT_LOW: idx = IDX_VOLT;
      `REG_CTRL: idx = IDX_CTRL;
      `REG_STATUS: idx = IDX_STATUS;
      `REG_AC_IRMS: idx = IDX_AC_IRMS;
      `REG_AC_ACTIVE: idx = IDX_AC_ACT;
      `REG_AC_REACTIVE: idx = IDX_AC_REACT;
      `REG_DC_IRMS: idx = IDX_DC_IRMS;
      `REG_DC_ACTIVE: idx = IDX_DC_ACT;
      default: idx = IDX_NONE;
    endcase
    return idx;
  endfunction : reg_index

  // Byte-lane merge into a 16-bit register; upper lanes are ignored
  // Lanes 2 and 3 carry nothing, as every register is 16 bits wide
  function automatic half_t merge16(input half_t old, input logic [31:0] data,
                                    input logic [3:0] strb);
    half_t res;
    res = old;
    if (strb[0])
      res[7:0] = data[7:0];
    if (strb[1])
      res[15:8] = data[15:8];
    return res;
  endfunction : merge16

  // Assembled offsets, MSB first: upper byte over the low word
  // The adder sees a change one clock after the register write,
  // so a sample in that clock still uses the old offset
  assign offs.current_offset = {state.upper[`UPPER_CUR_FIELD], state.cur_low};
  assign offs.voltage_offset = {state.upper[`UPPER_VOLT_FIELD], state.volt_low};

  // Next-state logic: bus slave, register writes, reads, save, mode
  // Everything below starts from a copy of the state and changes only
  // the fields that an event touches
  always_comb
  begin
    logic [3:0] widx;
    logic [3:0] ridx;
    logic [31:0] rword;
    logic do_write;
    widx = reg_index(state.aw_addr);
    ridx = reg_index(s_axi_araddr_i);
    rword = '0;
    do_write = state.aw_full && state.w_full && !state.bvalid;
    next_state = state;
    next_state.save_req = 1'b0;

    // Write address channel, taken independently of data
    if (s_axi_awvalid_i && state.awready)
    begin
      next_state.aw_full = 1'b1;
      next_state.aw_addr = s_axi_awaddr_i;
    end
    // Write data channel, may come before or after the address
    if (s_axi_wvalid_i && state.wready)
    begin
      next_state.w_full = 1'b1;
      next_state.w_data = s_axi_wdata_i;
      next_state.w_strb = s_axi_wstrb_i;
    end

    // Commit once both halves are held
    // Holding off while a response waits keeps one write in flight
    if (do_write)
    begin
      next_state.aw_full = 1'b0;
      next_state.w_full = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp = `RESP_OKAY;
      case (widx)
        IDX_UPPER:
          next_state.upper = merge16(state.upper, state.w_data, state.w_strb);
        IDX_CUR:
          next_state.cur_low = merge16(state.cur_low, state.w_data, state.w_strb);
        IDX_VOLT:
          next_state.volt_low = merge16(state.volt_low, state.w_data, state.w_strb);
        IDX_CTRL:
        begin
          if (state.w_strb[0])
          begin
            next_state.dc_mode = state.w_data[`CTRL_DC_BIT];
            // A second command while one is pending is dropped
            if (state.w_data[`CTRL_SAVE_BIT] && state.save == SAVE_IDLE)
              next_state.save = SAVE_REQ;
          end
        end
        IDX_STATUS:
          ;  // Read-only, write ignored
        IDX_AC_IRMS:
          next_state.ac_irms = merge16(state.ac_irms, state.w_data, state.w_strb);
        IDX_AC_ACT:
          next_state.ac_act = merge16(state.ac_act, state.w_data, state.w_strb);
        IDX_AC_REACT:
          next_state.ac_react = merge16(state.ac_react, state.w_data, state.w_strb);
        IDX_DC_IRMS:
          next_state.dc_irms = merge16(state.dc_irms, state.w_data, state.w_strb);
        IDX_DC_ACT:
          next_state.dc_act = merge16(state.dc_act, state.w_data, state.w_strb);
        default:
          next_state.bresp = `RESP_SLVERR;  // Unmapped address
      endcase
    end

    // Write response retires on bready
    // Set and clear never meet: a commit needs bvalid low
    if (state.bvalid && s_axi_bready_i)
      next_state.bvalid = 1'b0;

    // Read data word for the requested register
    // Upper halves read as zero; the control word shows the mode only,
    // the save bit is a command and reads back zero
    case (ridx)
      IDX_UPPER: rword = {16'h0000, state.upper};
      IDX_CUR: rword = {16'h0000, state.cur_low};
      IDX_VOLT: rword = {16'h0000, state.volt_low};
      IDX_CTRL: rword[`CTRL_DC_BIT] = state.dc_mode;
      IDX_STATUS:
      begin
        rword[`STAT_BUSY_BIT] = (state.save != SAVE_IDLE);
        rword[`STAT_DC_BIT] = state.dc_mode;
      end
      IDX_AC_IRMS: rword = {16'h0000, state.ac_irms};
      IDX_AC_ACT: rword = {16'h0000, state.ac_act};
      IDX_AC_REACT: rword = {16'h0000, state.ac_react};
      IDX_DC_IRMS: rword = {16'h0000, state.dc_irms};
      IDX_DC_ACT: rword = {16'h0000, state.dc_act};
      default: rword = '0;
    endcase

    // Read channel: one outstanding read, answered the next cycle
    // The address is decoded live, so the master must hold it with valid
    if (s_axi_arvalid_i && state.arready)
    begin
      next_state.rvalid = 1'b1;
      next_state.rdata = rword;
      next_state.rresp = (ridx == IDX_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end
    else if (state.rvalid && s_axi_rready_i)
      next_state.rvalid = 1'b0;

    // Save handshake; the store reads the live register outputs
    // A command during a save is dropped, not queued, so software must
    // poll the busy flag before asking again
    case (state.save)
      SAVE_IDLE:
        ;  // Waiting for a command
      SAVE_REQ:
      begin
        next_state.save_req = 1'b1;
        next_state.save = SAVE_WAIT;
      end
      SAVE_WAIT:
        if (save_done_i)
          next_state.save = SAVE_IDLE;
      default:
        next_state.save = SAVE_IDLE;
    endcase

    // Mode-dependent paths follow the mode register one cycle later
    // Registering the selection keeps the term outputs glitch free
    // when the mode flips in the middle of a calculation
    next_state.hpf_bypass = state.dc_mode;
    if (state.dc_mode)
    begin
      // DC has no reactive term; AC terms stay stored but unused
      next_state.off_irms = state.dc_irms;
      next_state.off_act = state.dc_act;
      next_state.off_react = `RST_TERM;
    end
    else
    begin
      next_state.off_irms = state.ac_irms;
      next_state.off_act = state.ac_act;
      next_state.off_react = state.ac_react;
    end

    // Ready flags registered so every output comes from a flop
    // Computed from the next state, so a ready never opens in the same
    // clock as the hold that should close it
    next_state.awready = !next_state.aw_full && !next_state.bvalid;
    next_state.wready = !next_state.w_full && !next_state.bvalid;
    next_state.arready = !next_state.rvalid;
  end

  // State register with reset values
  // Synchronous reset: the low words and upper bytes come back to
  // their power-on values, all else clears
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      state <= '0;
      state.upper <= `RST_UPPER_BYTES;
      state.cur_low <= `RST_CUR_LOW;
      state.volt_low <= `RST_VOLT_LOW;
      state.save <= SAVE_IDLE;
    end
    else
      state <= next_state;
  end

  // Offset adder ahead of all further processing
  // The adder has its own register stage; corrected codes trail
  // the raw codes by one clock
  offset_adder u_adder (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .offs(offs.sink),
    .current_code_i(current_code_i),
    .voltage_code_i(voltage_code_i),
    .code_valid_i(code_valid_i),
    .corrected_current_o(corrected_current_o),
    .corrected_voltage_o(corrected_voltage_o),
    .corrected_valid_o(corrected_valid_o)
  );

  // Outputs straight from the state register
  // No logic between flop and pin, so output timing is one clock
  assign s_axi_awready_o = state.awready;
  assign s_axi_wready_o = state.wready;
  assign s_axi_bvalid_o = state.bvalid;
  assign s_axi_bresp_o = state.bresp;
  assign s_axi_arready_o = state.arready;
  assign s_axi_rvalid_o = state.rvalid;
  assign s_axi_rdata_o = state.rdata;
  assign s_axi_rresp_o = state.rresp;
  assign hpf_bypass_o = state.hpf_bypass;
  assign offset_irms_o = state.off_irms;
  assign offset_active_o = state.off_act;
  assign offset_reactive_o = state.off_react;
  assign save_request_o = state.save_req;

endmodule : adc_offset_correction

// [src/offset_corr_params.svh]
/*
  Constants for the converter offset correction block: register byte
  offsets, field positions, reset values and bus response codes.
  Assumes inclusion by bare name from every design file that needs them.
*/
// What this block does
// - DC mode bypasses both channel high-pass filters
// - AC mode applies current, active, reactive offsets
// - DC mode applies its own current, active offsets
// - Software reads and writes 24-bit offsets through two 16-bit registers
// - Register holds current offset bits 15 to 0
// - Register holds voltage offset bits 15 to 0
// - Offset is upper byte above low word
// - Offset added to raw code before processing
// - Save command stores constants in nonvolatile memory
`ifndef OFFSET_CORR_PARAMS_SVH
`define OFFSET_CORR_PARAMS_SVH

// Register byte offsets on the AXI4-Lite slave
`define REG_UPPER_BYTES 8'h00
`define REG_CUR_LOW 8'h04
`define REG_VOLT_LOW 8'h08
`define REG_CTRL 8'h0c
`define REG_STATUS 8'h10
`define REG_AC_IRMS 8'h14
`define REG_AC_ACTIVE 8'h18
`define REG_AC_REACTIVE 8'h1c
`define REG_DC_IRMS 8'h20
`define REG_DC_ACTIVE 8'h24

// Reset values
`define RST_UPPER_BYTES 16'hffff
`define RST_CUR_LOW 16'h7d80
`define RST_VOLT_LOW 16'hec00
`define RST_TERM 16'h0000

// Field positions
`define UPPER_VOLT_FIELD 15:8
`define UPPER_CUR_FIELD 7:0
`define CTRL_DC_BIT 0
`define CTRL_SAVE_BIT 1
`define STAT_BUSY_BIT 0
`define STAT_DC_BIT 1

// Bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// [src/offset_corr_pkg.sv]
/*
  Types shared by the offset correction modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package offset_corr_pkg;

  typedef logic signed [23:0] code_t;  // Converter code or full offset
  typedef logic [15:0] half_t;         // One 16-bit register value

  // Save handshake toward the nonvolatile store
  typedef enum logic [1:0]
  {
    SAVE_IDLE = 2'b00,
    SAVE_REQ = 2'b01,
    SAVE_WAIT = 2'b10
  } save_state_e;

endpackage : offset_corr_pkg

// [src/offset_if.sv]
/*
  Carrier of the assembled 24-bit channel offsets between the register
  file and the offset adder. Assumes both ends share one clock.
*/
`timescale 1ns/100ps
interface offset_if;
  import offset_corr_pkg::*;
  code_t current_offset;  // Current channel offset, two's complement
  code_t voltage_offset;  // Voltage channel offset, two's complement
  modport source (output current_offset, output voltage_offset);
  modport sink (input current_offset, input voltage_offset);
endinterface : offset_if

// [src/offset_adder.sv]
/*
  Adds each channel's offset to its raw converter code, one register
  stage. Assumes codes arrive synchronous to mclk_i with a valid strobe.
*/
`timescale 1ns/100ps
module offset_adder (
  input wire logic mclk_i,
  input wire logic reset_i,
  offset_if.sink offs,
  input wire offset_corr_pkg::code_t current_code_i,
  input wire offset_corr_pkg::code_t voltage_code_i,
  input wire logic code_valid_i,
  output offset_corr_pkg::code_t corrected_current_o,
  output offset_corr_pkg::code_t corrected_voltage_o,
  output logic corrected_valid_o
);
  import offset_corr_pkg::*;

  // All state of the adder
  typedef struct packed {
    logic [1:0][23:0] corr;
    logic valid;
  } adder_s;

  adder_s state;
  adder_s next_state;
  code_t raw [2];   // Raw code per channel
  code_t offv [2];  // Offset per channel
  code_t sum [2];   // Wrapped sum per channel

  assign raw[0] = current_code_i;
  assign raw[1] = voltage_code_i;
  assign offv[0] = offs.current_offset;
  assign offv[1] = offs.voltage_offset;

  // Wraps like a bit-serial adder would; no saturation
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_chan
    assign sum[ch] = code_t'(raw[ch] + offv[ch]);
  end

  // Next state: capture sums on each valid code
  always_comb
  begin
    next_state = state;
    next_state.valid = code_valid_i;
    if (code_valid_i)
    begin
      next_state.corr[0] = sum[0];
      next_state.corr[1] = sum[1];
    end
  end

  // State register
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      state <= '0;
    else
      state <= next_state;
  end

  assign corrected_current_o = code_t'(state.corr[0]);
  assign corrected_voltage_o = code_t'(state.corr[1]);
  assign corrected_valid_o = state.valid;

endmodule : offset_adder

// [tb/adc_offset_properties.sv]
/*
  Checker for the offset correction block: bus handshakes, code path and
  save pulse. Assumes it is bound to the top module and sees its ports.
*/
`timescale 1ns/100ps
module adc_offset_checker (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic code_valid_i,
  input wire offset_corr_pkg::code_t corrected_current_o,
  input wire logic corrected_valid_o,
  input wire logic hpf_bypass_o,
  input wire offset_corr_pkg::half_t offset_reactive_o,
  input wire logic save_request_o
);
  import offset_corr_pkg::*;
  // One clock domain, so clock and reset are given once
  default clocking dc @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  AST_CORR_VALID: assert property (corrected_valid_o == $past(code_valid_i))
    else $error("corrected valid not one cycle after code valid");
  AST_CORR_HOLD: assert property (!code_valid_i |=> $stable(corrected_current_o))
    else $error("corrected code moved without a sample");
  AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped before taken");
  AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped before taken");
  AST_AW_REFUSE: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write accepted while response pending");
  AST_AR_REFUSE: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read accepted while data pending");
  AST_R_ANSWER: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read data late");
  AST_B_ANSWER: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o)
    else $error("write response not two cycles after take");
  AST_REACTIVE_DC: assert property (hpf_bypass_o |-> offset_reactive_o == 16'h0000)
    else $error("reactive term applied in dc mode");
  AST_SAVE_PULSE: assert property (save_request_o |=> !save_request_o)
    else $error("save request longer than one cycle");
  // Mode switch is seen at least once
  COV_DC: cover property ($rose(hpf_bypass_o));
endmodule : adc_offset_checker

bind adc_offset_correction adc_offset_checker adc_offset_checker_i (.*);

// [tb/nv_store_model.sv]
/*
  Nonvolatile store model: answers a save request with a one-cycle done
  pulse after DELAY cycles. Assumes the block's clock and reset.
*/
`timescale 1ns/100ps
module nv_store_model #(parameter int DELAY = 20) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic req_i,
  output logic done_o = 1'b0
);
  int cnt; // Cycles left until the store is written
  // A slow answer keeps the busy window open for a repeated command
  always @(posedge mclk_i)
  begin
    done_o <= 1'b0;
    if (reset_i)
      cnt <= 0;
    else if (req_i)
      cnt <= DELAY;
    else if (cnt == 1)
    begin
      cnt <= 0;
      done_o <= 1'b1;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule : nv_store_model

// [tb/tb_top.sv]
/*
  Bench for the offset correction block: AXI4-Lite tasks, code samples
  and expected values. Assumes design, package and header compile first.
*/
`timescale 1ns/100ps
`include "offset_corr_params.svh"
module tb_top;
  import offset_corr_pkg::*;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
  logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o, rd;
  logic [3:0] s_axi_wstrb_i = 4'h3;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, code_valid_i = 1'b0;
  code_t current_code_i = '0, voltage_code_i = '0, corrected_current_o, corrected_voltage_o;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic corrected_valid_o, hpf_bypass_o, save_request_o, save_done_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rsp;
  half_t offset_irms_o, offset_active_o, offset_reactive_o;
  half_t up = 16'hffff, cl = 16'h7d80, vl = 16'hec00; // Expected register contents
  int num_errors = 0, check_count = 0, saves = 0, w;
  int lag = 0; // Cycles the master waits before raising bready or rready

  always #20 mclk_i = ~mclk_i;
  adc_offset_correction adc_offset_correction_i (.*);
  nv_store_model nv_store_model_i (.mclk_i, .reset_i, .req_i(save_request_o), .done_o(save_done_i));
  // Count save pulses so a dropped or doubled request shows
  always @(posedge mclk_i) if (save_request_o === 1'b1) saves++;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task complete_run;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  // A missing answer ends the run
  task give_up;
    num_errors++;
    $display("BAD %0t no answer", $time);
    complete_run;
  endtask : give_up

  task rst;
    reset_i <= 1'b1;
    repeat (12) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
  endtask : rst

  // Write: both halves offered together, each dropped when taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic got;
    got = 1'b0;
    w = 0;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= (lag == 0);
    while (got !== 1'b1 && w < 64)
    begin
      @(posedge mclk_i);
      w++;
      if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
      got = s_axi_bvalid_o & s_axi_bready_i;
      rsp = s_axi_bresp_o;
      // A late bready makes the slave hold its response
      if (w >= lag && got !== 1'b1) s_axi_bready_i <= 1'b1;
    end
    if (got !== 1'b1) give_up;
    s_axi_bready_i <= 1'b0;
    @(posedge mclk_i);
  endtask : wr

  task rdr(input logic [7:0] a);
    logic got;
    got = 1'b0;
    w = 0;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= (lag == 0);
    while (got !== 1'b1 && w < 64)
    begin
      @(posedge mclk_i);
      w++;
      if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
      got = s_axi_rvalid_o & s_axi_rready_i;
      rd = s_axi_rdata_o;
      rsp = s_axi_rresp_o;
      // A late rready makes the slave hold its data
      if (w >= lag && got !== 1'b1) s_axi_rready_i <= 1'b1;
    end
    if (got !== 1'b1) give_up;
    s_axi_rready_i <= 1'b0;
    @(posedge mclk_i);
  endtask : rdr

  // One sample through the adder, checked once settled
  task smp(input code_t c, input code_t v);
    current_code_i <= c;
    voltage_code_i <= v;
    code_valid_i <= 1'b1;
    @(posedge mclk_i);
    code_valid_i <= 1'b0;
    @(negedge mclk_i);
    chk(corrected_valid_o, 1'b1);
    chk(corrected_current_o, code_t'(c + {up[7:0], cl}));
    chk(corrected_voltage_o, code_t'(v + {up[15:8], vl}));
    @(posedge mclk_i);
  endtask : smp

  initial
  begin
    rst;
    wr(`REG_CUR_LOW, 32'h1);
    rst;
    rdr(`REG_UPPER_BYTES);
    chk(rd, 32'h0000ffff);
    rdr(`REG_CUR_LOW);
    chk(rd, 32'h00007d80);
    rdr(`REG_VOLT_LOW);
    chk(rd, 32'h0000ec00);
    smp(24'h000100, 24'h000200);
    up = 16'h12fe;
    cl = 16'h3456;
    vl = 16'h789a;
    wr(`REG_UPPER_BYTES, {16'h0, up});
    chk(rsp, `RESP_OKAY);
    wr(`REG_CUR_LOW, {16'h0, cl});
    // Slow master: responses must stand until taken
    lag = 3;
    wr(`REG_VOLT_LOW, {16'h0, vl});
    rdr(`REG_UPPER_BYTES);
    lag = 0;
    chk(rd, {16'h0, up});
    // Lane 0 only: upper byte of the word must survive
    s_axi_wstrb_i <= 4'h1;
    wr(`REG_CUR_LOW, 32'h0000ffaa);
    s_axi_wstrb_i <= 4'h3;
    cl[7:0] = 8'haa;
    rdr(`REG_CUR_LOW);
    chk(rd, {16'h0, cl});
    rdr(`REG_VOLT_LOW);
    chk(rd, {16'h0, vl});
    smp(24'h001000, 24'h7ff000);
    // Unmapped place is refused both ways
    wr(8'h40, 32'h5a5a);
    chk(rsp, `RESP_SLVERR);
    rdr(8'h40);
    chk(rsp, `RESP_SLVERR);
    chk(rd, 32'h0);
    // Status is read-only: a write is answered but changes nothing
    wr(`REG_STATUS, 32'h3);
    chk(rsp, `RESP_OKAY);
    rdr(`REG_STATUS);
    chk(rd, 32'h0);
    for (int i = 0; i < 5; i++) wr(`REG_AC_IRMS + 8'(4 * i), 32'h1111 * (i + 1));
    chk(hpf_bypass_o, 1'b0);
    chk(offset_irms_o, 16'h1111);
    chk(offset_active_o, 16'h2222);
    chk(offset_reactive_o, 16'h3333);
    wr(`REG_CTRL, 32'h1);
    chk(hpf_bypass_o, 1'b1);
    chk(offset_irms_o, 16'h4444);
    chk(offset_active_o, 16'h5555);
    chk(offset_reactive_o, 16'h0);
    rdr(`REG_STATUS);
    chk(rd[1], 1'b1);
    wr(`REG_CTRL, 32'h0);
    chk(hpf_bypass_o, 1'b0);
    chk(offset_irms_o, 16'h1111);
    // Codes stay idle while saving, as for an unloaded system
    wr(`REG_CTRL, 32'h2);
    rdr(`REG_STATUS);
    chk(rd[0], 1'b1);
    wr(`REG_CTRL, 32'h2);
    w = 0;
    while (save_done_i !== 1'b1 && w < 200)
    begin
      @(posedge mclk_i);
      w++;
    end
    if (w == 200) give_up;
    @(posedge mclk_i);
    rdr(`REG_STATUS);
    chk(rd[0], 1'b0);
    chk(saves, 1);
    complete_run;
  end
endmodule : tb_top
